// >>> bench/psb_bridge_checker.sv
// Purpose: port-level assertions for the bus bridge
// Assumes: one clock domain
// Notes:   attached by bind below
`timescale 1ns/10ps
module psb_bridge_checker (
  input wire       sys_clk,
  input wire       sys_rst,
  input wire [4:0] bus_cmd_sense_n,
  input wire       command_ack_primary_n_out,
  input wire       command_ack_primary_oe,
  input wire       bus_error_flag,
  input wire       bus_timeout_irq,
  input wire       status_read_strobe,
  input wire       sys_bus_clk,
  input wire       cpu_clk,
  input wire       cpu_reset,
  input wire       mem_read_cmd_n,
  input wire       mem_write_cmd_n,
  input wire       io_read_cmd_n,
  input wire       io_write_cmd_n,
  input wire       sys_cmd_oe,
  input wire       sys_addr_oe,
  input wire       bus_busy_n_out,
  input wire       bus_busy_oe,
  input wire [7:0] mem_region_sel,
  input wire [7:0] io_region_sel
);
  wire [3:0] cmd_n = {mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n,
                      io_write_cmd_n};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // *****
  // assertions
  // *****
  a_ack_substitute: assert property ($rose(command_ack_primary_oe) |->
    !command_ack_primary_n_out && !(&bus_cmd_sense_n))
    else $error("stray ack");
  a_err_with_ack: assert property ($rose(command_ack_primary_oe) |->
    ##[0:2] bus_error_flag && bus_timeout_irq)
    else $error("flags missing");
  a_ack_release: assert property ($rose(&bus_cmd_sense_n) |->
    ##[1:5] !command_ack_primary_oe)
    else $error("ack held");
  a_status_clear: assert property (status_read_strobe |->
    ##[1:2] !bus_error_flag && !bus_timeout_irq)
    else $error("flags stuck");
  a_strobe_pulse: assert property (status_read_strobe |=>
    !status_read_strobe)
    else $error("strobe too long");
  a_bus_clk_half: assert property ($rose(sys_bus_clk) |=>
    sys_bus_clk [*4] ##1 !sys_bus_clk)
    else $error("bus clock width");
  a_cpu_clk_half: assert property ($changed(cpu_clk) |=>
    $stable(cpu_clk) [*8])
    else $error("cpu clock width");
  a_reset_sync: assert property ($changed(cpu_reset) |->
    cpu_clk)
    else $error("reset off clock");
  a_cmd_master: assert property (!(&cmd_n) |-> sys_cmd_oe &&
    $onehot0(~cmd_n))
    else $error("bad command");
  a_busy_addr: assert property ($rose(sys_addr_oe) |->
    bus_busy_oe && !bus_busy_n_out)
    else $error("busy missing");
  a_region_onehot: assert property ($onehot0(mem_region_sel) &&
    $onehot0(io_region_sel))
    else $error("select not one-hot");
  c_timeout: cover property ($rose(command_ack_primary_oe));
  c_status: cover property (status_read_strobe);
  c_master: cover property ($rose(sys_addr_oe));
endmodule
bind psb_bridge psb_bridge_checker i_chk (.*);

// >>> bench/psb_slave.sv
// Purpose: far-side slave board and bus priority logic
// Assumes: command and ack lines are active low with pull-ups
// Notes:   acks commands after four cycles when ack_en
`timescale 1ns/10ps
module psb_slave #(
  parameter [15:0] RD_WORD = 16'hC35A
) (
  input  wire        sys_clk,
  input  wire [4:0]  cmd_n,
  input  wire        ack_en,
  input  wire        req_n,
  output reg         ack_n = 1'b1,
  output reg         gnt_n = 1'b1,
  output reg  [15:0] rd_data = 16'hFFFF
);
  reg [1:0] wait_cnt = 2'h0;
  // *****
  // answer commands, grant requests
  // *****
  always @(posedge sys_clk) begin
    gnt_n <= req_n;
    if (&cmd_n) begin
      wait_cnt <= 2'h0;
      ack_n    <= 1'b1;
      rd_data  <= ~rd_data; // undriven
    end else if (ack_en && wait_cnt == 2'h3) begin
      ack_n   <= 1'b0;
      rd_data <= RD_WORD;
    end else if (ack_n) begin
      wait_cnt <= wait_cnt + 2'h1;
      rd_data  <= ~rd_data;
    end
  end
endmodule

// >>> bench/testbench.sv
// Purpose: self-checking bench for the bus bridge
// Assumes: foreign master drives mst_n
// Notes:   timer ticks while tick_on
`timescale 1ns/10ps
`include "psb_consts.vh"
module testbench;
  reg         sys_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [19:0] muxed_ad_in = 20'h0;
  reg         addr_latch_strobe = 1'b0;
  reg  [2:0]  cs = 3'h7;
  reg         ext_reset_in = 1'b0;
  reg         ext_ready_in = 1'b1;
  reg         board_status_a_n = 1'b0;
  reg         board_status_b_n = 1'b1;
  reg         timer_chan_out = 1'b0;
  reg         tick_on = 1'b0;
  reg         ack_en = 1'b1;
  reg  [4:0]  mst_n = 5'h1F;
  reg  [4:0]  cmd_seen;
  integer     n_mismatch = 0;
  integer     compares = 0;
  integer     cyc = 0;
  integer     n, n_cpu, n_bus;
  wire        cycle_state_0 = cs[0];
  wire        cycle_state_1 = cs[1];
  wire        cycle_state_2 = cs[2];
  wire [15:0] muxed_ad_out, local_data, sys_data_out, slv_data;
  wire [19:0] local_addr, sys_addr_out;
  wire [7:0]  io_region_sel, mem_region_sel;
  wire muxed_ad_oe, cpu_clk, cpu_reset, cpu_ready, inta_cycle, halt_cycle,
    sys_addr_oe, sys_data_oe, mem_read_cmd_n, mem_write_cmd_n,
    io_read_cmd_n, io_write_cmd_n, early_io_write_cmd_n, sys_cmd_oe,
    command_ack_primary_n_out, command_ack_primary_oe, bus_request_n,
    bus_priority_grant_in_n, bus_busy_n_out, bus_busy_oe, sys_bus_clk,
    status_read_strobe, bus_error_flag, bus_timeout_irq, slv_ack_n;
  wire        command_ack_secondary_n_in = 1'b1;
  wire [15:0] sys_data_in = sys_data_oe ? sys_data_out : slv_data;
  wire [4:0]  bus_cmd_sense_n = mst_n & {mem_read_cmd_n,
    mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n,
    early_io_write_cmd_n};
  wire command_ack_primary_n_in = slv_ack_n &
    (command_ack_primary_oe ? command_ack_primary_n_out : 1'b1);
  wire bus_busy_n_in = bus_busy_oe ? bus_busy_n_out : 1'b1;

  psb_bridge i_dut (.*);
  psb_slave i_slave (.sys_clk(sys_clk), .cmd_n(bus_cmd_sense_n),
    .ack_en(ack_en), .req_n(bus_request_n), .ack_n(slv_ack_n),
    .gnt_n(bus_priority_grant_in_n), .rd_data(slv_data));
  // *****
  // clocks, edge counters, watchdog
  // *****
  initial forever #5 sys_clk = ~sys_clk;
  always #62.5 if (tick_on) timer_chan_out = ~timer_chan_out;
  always @(posedge cpu_clk) n_cpu = n_cpu + 1;
  always @(posedge sys_bus_clk) n_bus = n_bus + 1;
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end
  // *****
  // tasks
  // *****
  task chk(input [19:0] e, input [19:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      if (n_mismatch == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task clk(input integer k);
    begin
      repeat (k) @(posedge sys_clk);
      #1;
    end
  endtask
  // one processor cycle
  task pcyc(input [2:0] c, input [19:0] a, input [15:0] d);
    integer k;
    begin
      cmd_seen = 5'h1F;
      muxed_ad_in = a;
      cs = c;
      addr_latch_strobe = 1'b1;
      clk(3);
      addr_latch_strobe = 1'b0;
      muxed_ad_in = {4'h0, d};
      k = 0;
      while (command_ack_primary_n_in && !muxed_ad_oe && k < 80) begin
        clk(1);
        cmd_seen = cmd_seen & bus_cmd_sense_n;
        k = k + 1;
      end
      clk(4);
    end
  endtask
  task pend;
    begin
      cs = 3'h7;
      clk(8);
    end
  endtask
  task t_clocks;
    begin
      ext_reset_in = 1'b1;
      ext_ready_in = 1'b0;
      clk(60);
      chk(2'b10, {cpu_reset, cpu_ready});
      ext_reset_in = 1'b0;
      ext_ready_in = 1'b1;
      clk(60);
      chk(2'b01, {cpu_reset, cpu_ready});
      n_cpu = 0;
      n_bus = 0;
      clk(2035);
      chk(1'b1, n_cpu >= 99 && n_cpu <= 100);
      chk(1'b1, n_bus >= 203 && n_bus <= 204);
    end
  endtask
  task t_memrd;
    begin
      pcyc(`PSB_CYC_MEMR, 20'h2A468, 16'h0);
      chk(20'h2A468, local_addr);
      chk(20'h2A468, sys_addr_out);
      chk(8'h02, mem_region_sel);
      chk(1'b0, cmd_seen[4]);
      chk(16'hC35A, muxed_ad_out);
      pend;
      chk(8'h00, mem_region_sel);
      chk(1'b1, mem_read_cmd_n);
    end
  endtask
  task t_iowr;
    begin
      pcyc(`PSB_CYC_IOW, 20'h00480, 16'hBEEF);
      chk(8'h02, io_region_sel);
      chk(16'hBEEF, local_data);
      chk(16'hBEEF, sys_data_out);
      chk(1'b0, cmd_seen[1]);
      pend;
    end
  endtask
  task t_state;
    begin
      pcyc(`PSB_CYC_HALT, 20'h0, 16'h0);
      chk(2'b01, {inta_cycle, halt_cycle});
      pend;
      pcyc(`PSB_CYC_INTA, 20'h0, 16'h0);
      chk(2'b10, {inta_cycle, halt_cycle});
      pend;
    end
  endtask
  task t_noto;
    begin
      mst_n = 5'h1E;
      tick_on = 1'b1;
      clk(80);
      chk(3'h0, {bus_error_flag, bus_timeout_irq,
                 command_ack_primary_oe});
      mst_n = 5'h1F;
      tick_on = 1'b0;
      clk(8);
    end
  endtask
  task t_timeout;
    begin
      ack_en = 1'b0;
      mst_n = 5'h17;
      clk(100);
      chk(1'b0, command_ack_primary_oe);
      tick_on = 1'b1;
      n = 0;
      while (!command_ack_primary_oe && n < 100) begin
        clk(1);
        n = n + 1;
      end
      clk(3);
      chk(1'b0, command_ack_primary_n_in);
      chk(2'b11, {bus_error_flag, bus_timeout_irq});
      tick_on = 1'b0;
      mst_n = 5'h1F;
      clk(8);
      chk(1'b1, command_ack_primary_n_in);
      pcyc(`PSB_CYC_IOR, 20'h000F0, 16'h0);
      chk(3'b101, muxed_ad_out[2:0]);
      pend;
      chk(2'b00, {bus_error_flag, bus_timeout_irq});
      ack_en = 1'b1;
    end
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    clk(8);
    t_clocks;
    t_memrd;
    t_iowr;
    t_state;
    t_noto;
    t_timeout;
    finish_test;
  end
endmodule

// >>> pkg/psb_consts.vh
// Purpose: constants for the processor to system bus bridge
// Assumes: 100 MHz sys_clk
// Notes:   included by every design file of the bridge
`ifndef PSB_CONSTS_VH
`define PSB_CONSTS_VH

// ****************************************************************
// clocking
// ****************************************************************
`define PSB_SYS_HZ        64'd100000000
`define PSB_CPU_HZ        64'd4915200
`define PSB_ACC_W         24
`define PSB_CPU_INC       ((`PSB_CPU_HZ << `PSB_ACC_W) / `PSB_SYS_HZ)
`define PSB_BCLK_HALF     3'h5
`define PSB_BCLK_RST      3'h0

// ****************************************************************
// processor cycle-state codes {s2,s1,s0}
// ****************************************************************
`define PSB_CYC_INTA      3'h0
`define PSB_CYC_IOR       3'h1
`define PSB_CYC_IOW       3'h2
`define PSB_CYC_HALT      3'h3
`define PSB_CYC_FETCH     3'h4
`define PSB_CYC_MEMR      3'h5
`define PSB_CYC_MEMW      3'h6
`define PSB_CYC_IDLE      3'h7

// ****************************************************************
// address map
// ****************************************************************
`define PSB_STAT_IO_ADDR  16'h00F0
`define PSB_ROM_REGION    4'hF
`define PSB_IO_LOCAL_HI   8'h00
`define PSB_IO_SEL_LSB    7
`define PSB_MEM_SEL_LSB   17

// ****************************************************************
// status word and timeout
// ****************************************************************
`define PSB_STAT_A_BIT    0
`define PSB_STAT_B_BIT    1
`define PSB_STAT_ERR_BIT  2
`define PSB_TMO_TICKS     2'h2

// ****************************************************************
// synchroniser bundle layout
// ****************************************************************
`define PSB_SYNC_W        54
`define PSB_SYNC_RST      54'h0
`endif

// >>> src/psb_bridge.v
// Purpose: bridge from a multiplexed processor bus to a backplane bus
// Assumes: 100 MHz sys_clk, all pins asynchronous to it
// Notes:   bus commands, ack and busy are active low open-drain lines
//
// Summary of operation
// - unanswered command gets a substitute acknowledge driven by us
// - missed acknowledge sets an error flag and raises an interrupt
// - multiplexed bus split into local and system address and data
// - local address bits decoded into memory and I/O region selects
// - cycle-state lines decoded to type and sequence each cycle
// - request, grant and busy decide who may use the system bus
// - memory and I/O commands driven for system-directed transfers
// - processor clock generated at 4.9152 MHz
// - reset and ready synchronised to processor clock
// - free-running system bus clock generated for all boards
// - two board status bits readable, status read strobe to detector
// - timeout length set by a programmable timer channel
`timescale 1ns/10ps
`include "psb_consts.vh"

module psb_bridge (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [19:0] muxed_ad_in,
  output reg  [15:0] muxed_ad_out,
  output reg         muxed_ad_oe,
  input  wire        addr_latch_strobe,
  input  wire        cycle_state_0,
  input  wire        cycle_state_1,
  input  wire        cycle_state_2,
  input  wire        ext_reset_in,
  input  wire        ext_ready_in,
  output reg         cpu_clk,
  output reg         cpu_reset,
  output reg         cpu_ready,
  output reg  [19:0] local_addr,
  output reg  [15:0] local_data,
  output reg  [7:0]  io_region_sel,
  output reg  [7:0]  mem_region_sel,
  output reg         inta_cycle,
  output reg         halt_cycle,
  output reg  [19:0] sys_addr_out,
  output reg         sys_addr_oe,
  input  wire [15:0] sys_data_in,
  output reg  [15:0] sys_data_out,
  output reg         sys_data_oe,
  output reg         mem_read_cmd_n,
  output reg         mem_write_cmd_n,
  output reg         io_read_cmd_n,
  output reg         io_write_cmd_n,
  output reg         early_io_write_cmd_n,
  output reg         sys_cmd_oe,
  input  wire [4:0]  bus_cmd_sense_n,
  input  wire        command_ack_primary_n_in,
  output reg         command_ack_primary_n_out,
  output reg         command_ack_primary_oe,
  input  wire        command_ack_secondary_n_in,
  output reg         bus_request_n,
  input  wire        bus_priority_grant_in_n,
  input  wire        bus_busy_n_in,
  output reg         bus_busy_n_out,
  output reg         bus_busy_oe,
  output reg         sys_bus_clk,
  input  wire        board_status_a_n,
  input  wire        board_status_b_n,
  input  wire        timer_chan_out,
  output reg         status_read_strobe,
  output reg         bus_error_flag,
  output reg         bus_timeout_irq
);

  // ****************************************************************
  // master state machine codes
  // ****************************************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_REQ  = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_CMD  = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam [63:0] CPU_INC_FULL = `PSB_CPU_INC;

  // one-hot of a three-bit field
  function [7:0] onehot3;
    input [2:0] v;
    begin
      onehot3 = 8'h01 << v;
    end
  endfunction

  // system-directed cycle test
  function is_sys;
    input [2:0]  cyc;
    input [19:0] a;
    begin
      case (cyc)
        `PSB_CYC_MEMR, `PSB_CYC_MEMW, `PSB_CYC_FETCH: begin
          is_sys = (a[19:16] != `PSB_ROM_REGION);
        end
        `PSB_CYC_IOR, `PSB_CYC_IOW: begin
          is_sys = (a[15:8] != `PSB_IO_LOCAL_HI);
        end
        default: begin
          is_sys = 1'b0;
        end
      endcase
    end
  endfunction

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  wire [`PSB_SYNC_W-1:0] sync_in;
  wire [`PSB_SYNC_W-1:0] sync_q;
  wire [19:0] ad_s;
  wire        ale_s;
  wire [2:0]  cs_s;
  wire        rst_s;
  wire        rdy_s;
  wire [15:0] sdat_s;
  wire [4:0]  cmd_s_n;
  wire        ack1_s_n;
  wire        ack2_s_n;
  wire        grant_s_n;
  wire        busy_s_n;
  wire        stat_a_s_n;
  wire        stat_b_s_n;
  wire        tmr_s;

  assign sync_in = {muxed_ad_in, addr_latch_strobe, cycle_state_2,
                    cycle_state_1, cycle_state_0, ext_reset_in,
                    ext_ready_in, sys_data_in, bus_cmd_sense_n,
                    command_ack_primary_n_in,
                    command_ack_secondary_n_in,
                    bus_priority_grant_in_n, bus_busy_n_in,
                    board_status_a_n, board_status_b_n,
                    timer_chan_out};
  assign {ad_s, ale_s, cs_s, rst_s, rdy_s, sdat_s, cmd_s_n,
          ack1_s_n, ack2_s_n, grant_s_n, busy_s_n, stat_a_s_n,
          stat_b_s_n, tmr_s} = sync_q;

  psb_sync #(
    .W        (`PSB_SYNC_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  // ****************************************************************
  // edge detection and derived conditions
  // ****************************************************************
  reg         ale_d;
  reg         tmr_d;
  wire        ale_rise;
  wire        tmr_tick;
  wire        any_cmd;
  wire        ack_seen;
  wire        ack_drive;
  wire        err_flag;
  wire        irq;
  reg  [2:0]  cyc;
  reg         sys_pend;
  reg         stat_rd;
  reg  [2:0]  state;
  reg  [2:0]  next_state;

  assign ale_rise = ale_s && !ale_d;
  assign tmr_tick = tmr_s && !tmr_d;
  assign any_cmd  = (cmd_s_n != 5'h1F);
  assign ack_seen = !ack1_s_n || !ack2_s_n;

  // previous samples for edge finding
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ale_d <= 1'b0;
      tmr_d <= 1'b0;
    end else begin
      ale_d <= ale_s;
      tmr_d <= tmr_s;
    end
  end

  // ****************************************************************
  // processor and bus clocks
  // ****************************************************************
  reg  [`PSB_ACC_W-1:0] cpu_acc;
  reg  [2:0]            bclk_cnt;
  wire                  cpu_edge;

  assign cpu_edge = !cpu_clk && cpu_acc[`PSB_ACC_W-1];

  // phase accumulator, top bit is the processor clock
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_acc <= {`PSB_ACC_W{1'b0}};
      cpu_clk <= 1'b0;
    end else begin
      cpu_acc <= cpu_acc + CPU_INC_FULL[`PSB_ACC_W-1:0];
      cpu_clk <= cpu_acc[`PSB_ACC_W-1];
    end
  end

  // free-running divider for the backplane clock
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bclk_cnt    <= `PSB_BCLK_RST;
      sys_bus_clk <= 1'b0;
    end else if (bclk_cnt == `PSB_BCLK_HALF - 3'h1) begin
      bclk_cnt    <= `PSB_BCLK_RST;
      sys_bus_clk <= !sys_bus_clk;
    end else begin
      bclk_cnt <= bclk_cnt + 3'h1;
    end
  end

  // reset and ready retimed to the processor clock edge
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_reset <= 1'b1;
      cpu_ready <= 1'b0;
    end else if (cpu_edge) begin
      cpu_reset <= rst_s;
      cpu_ready <= rdy_s && !sys_pend;
    end
  end

  // ****************************************************************
  // cycle capture, demultiplexing and decode
  // ****************************************************************
  // latch address and cycle type at the address strobe
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      local_addr     <= 20'h00000;
      local_data     <= 16'h0000;
      cyc            <= `PSB_CYC_IDLE;
      io_region_sel  <= 8'h00;
      mem_region_sel <= 8'h00;
      inta_cycle     <= 1'b0;
      halt_cycle     <= 1'b0;
      sys_pend       <= 1'b0;
    end else if (ale_rise) begin
      local_addr <= ad_s;
      cyc        <= cs_s;
      inta_cycle <= (cs_s == `PSB_CYC_INTA);
      halt_cycle <= (cs_s == `PSB_CYC_HALT);
      sys_pend   <= is_sys(cs_s, ad_s);
      io_region_sel <= (cs_s == `PSB_CYC_IOR || cs_s == `PSB_CYC_IOW) ?
        onehot3(ad_s[`PSB_IO_SEL_LSB+2:`PSB_IO_SEL_LSB]) : 8'h00;
      mem_region_sel <= (cs_s[2] && cs_s != `PSB_CYC_IDLE) ?
        onehot3(ad_s[`PSB_MEM_SEL_LSB+2:`PSB_MEM_SEL_LSB]) : 8'h00;
    end else begin
      local_data <= ad_s[15:0];
      if (cs_s == `PSB_CYC_IDLE) begin
        io_region_sel  <= 8'h00;
        mem_region_sel <= 8'h00;
        cyc            <= `PSB_CYC_IDLE;
      end
      if (state == ST_DONE) begin
        sys_pend <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // status read
  // ****************************************************************
  // one pulse per strobe of the status address
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_rd            <= 1'b0;
      status_read_strobe <= 1'b0;
    end else begin
      stat_rd <= ale_rise && cs_s == `PSB_CYC_IOR &&
                 ad_s[15:0] == `PSB_STAT_IO_ADDR;
      status_read_strobe <= stat_rd;
    end
  end

  // ****************************************************************
  // bus mastership state machine
  // ****************************************************************
  // request, wait for grant and free bus, command, wait ack
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sys_pend) begin
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!grant_s_n && busy_s_n) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        next_state = ST_CMD;
      end
      ST_CMD: begin
        if (ack_seen) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (cs_s == `PSB_CYC_IDLE) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // system bus drive
  // ****************************************************************
  // address, data, commands and busy follow the state
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_request_n        <= 1'b1;
      bus_busy_n_out       <= 1'b1;
      bus_busy_oe          <= 1'b0;
      sys_addr_out         <= 20'h00000;
      sys_addr_oe          <= 1'b0;
      sys_data_out         <= 16'h0000;
      sys_data_oe          <= 1'b0;
      mem_read_cmd_n       <= 1'b1;
      mem_write_cmd_n      <= 1'b1;
      io_read_cmd_n        <= 1'b1;
      io_write_cmd_n       <= 1'b1;
      early_io_write_cmd_n <= 1'b1;
      sys_cmd_oe           <= 1'b0;
    end else begin
      bus_request_n  <= !(next_state == ST_REQ);
      bus_busy_oe    <= (next_state == ST_ADDR ||
                         next_state == ST_CMD);
      bus_busy_n_out <= !(next_state == ST_ADDR ||
                          next_state == ST_CMD);
      sys_addr_out   <= local_addr;
      sys_addr_oe    <= (next_state == ST_ADDR ||
                         next_state == ST_CMD);
      sys_data_out   <= local_data;
      sys_data_oe    <= (next_state == ST_ADDR ||
                         next_state == ST_CMD) &&
                        (cyc == `PSB_CYC_MEMW || cyc == `PSB_CYC_IOW);
      sys_cmd_oe     <= (next_state == ST_ADDR ||
                         next_state == ST_CMD);
      mem_read_cmd_n <= !(next_state == ST_CMD &&
        (cyc == `PSB_CYC_MEMR || cyc == `PSB_CYC_FETCH));
      mem_write_cmd_n <= !(next_state == ST_CMD &&
        cyc == `PSB_CYC_MEMW);
      io_read_cmd_n <= !(next_state == ST_CMD &&
        cyc == `PSB_CYC_IOR);
      io_write_cmd_n <= !(next_state == ST_CMD &&
        cyc == `PSB_CYC_IOW);
      early_io_write_cmd_n <= !((next_state == ST_ADDR ||
        next_state == ST_CMD) && cyc == `PSB_CYC_IOW);
    end
  end

  // ****************************************************************
  // return data to the processor
  // ****************************************************************
  // system read data or status word driven until the cycle ends
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      muxed_ad_out <= 16'h0000;
      muxed_ad_oe  <= 1'b0;
    end else if (stat_rd) begin
      muxed_ad_out <= 16'h0000;
      muxed_ad_out[`PSB_STAT_A_BIT]   <= !stat_a_s_n;
      muxed_ad_out[`PSB_STAT_B_BIT]   <= !stat_b_s_n;
      muxed_ad_out[`PSB_STAT_ERR_BIT] <= err_flag;
      muxed_ad_oe  <= 1'b1;
    end else if (state == ST_CMD && ack_seen &&
                 (cyc == `PSB_CYC_MEMR || cyc == `PSB_CYC_IOR ||
                  cyc == `PSB_CYC_FETCH)) begin
      muxed_ad_out <= sdat_s;
      muxed_ad_oe  <= 1'b1;
    end else if (cs_s == `PSB_CYC_IDLE) begin
      muxed_ad_oe  <= 1'b0;
    end
  end

  // ****************************************************************
  // bus timeout detector
  // ****************************************************************
  psb_timeout u_tmo (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .cmd_active (any_cmd),
    .ack_seen   (ack_seen),
    .tick       (tmr_tick),
    .stat_rd    (status_read_strobe),
    .ack_drive  (ack_drive),
    .err_flag   (err_flag),
    .irq        (irq)
  );

  // substitute acknowledge and flags onto the pins
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      command_ack_primary_n_out <= 1'b1;
      command_ack_primary_oe    <= 1'b0;
      bus_error_flag            <= 1'b0;
      bus_timeout_irq           <= 1'b0;
    end else begin
      command_ack_primary_n_out <= !ack_drive;
      command_ack_primary_oe    <= ack_drive;
      bus_error_flag            <= err_flag;
      bus_timeout_irq           <= irq;
    end
  end

endmodule

// >>> src/psb_sync.v
// Purpose: two-flop synchroniser for a bundle of asynchronous inputs
// Assumes: each bit is an independent level
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
`include "psb_consts.vh"

module psb_sync #(
  parameter W = `PSB_SYNC_W
) (
  input  wire         sys_clk,
  input  wire         sys_rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  // ****************************************************************
  // per-bit double flop
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      // sample then resample to settle metastability
      always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule

// >>> src/psb_timeout.v
// Purpose: system bus timeout detector
// Assumes: tick is a one-cycle pulse from an interval timer channel
// Notes:   substitute acknowledge holds until the command is removed
`timescale 1ns/10ps
`include "psb_consts.vh"

module psb_timeout (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire cmd_active,
  input  wire ack_seen,
  input  wire tick,
  input  wire stat_rd,
  output reg  ack_drive,
  output reg  err_flag,
  output reg  irq
);

  reg  [1:0] tick_cnt;
  wire       expire;

  // timeout when enough timer intervals pass with no acknowledge
  assign expire = cmd_active && !ack_seen && tick &&
                  (tick_cnt == `PSB_TMO_TICKS - 2'h1);

  // ****************************************************************
  // interval counting
  // ****************************************************************
  // count runs only while a command stands unanswered
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 2'h0;
    end else if (!cmd_active || ack_seen) begin
      tick_cnt <= 2'h0;
    end else if (tick && tick_cnt != `PSB_TMO_TICKS) begin
      tick_cnt <= tick_cnt + 2'h1;
    end
  end

  // ****************************************************************
  // substitute acknowledge, error flag and interrupt
  // ****************************************************************
  // set wins over the clear from a status read
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_drive <= 1'b0;
      err_flag  <= 1'b0;
      irq       <= 1'b0;
    end else begin
      if (expire) begin
        ack_drive <= 1'b1;
      end else if (!cmd_active) begin
        ack_drive <= 1'b0;
      end
      if (expire) begin
        err_flag <= 1'b1;
        irq      <= 1'b1;
      end else if (stat_rd) begin
        err_flag <= 1'b0;
        irq      <= 1'b0;
      end
    end
  end

endmodule
